// ===== core/rfc_regs.vh
`ifndef RFC_REGS_VH
`define RFC_REGS_VH
// register indexes, byte address is four times the index
`define RFC_IDX_SIG_CTRL 8'h13
`define RFC_IDX_MODE14 8'h14
`define RFC_IDX_BOC_CTRL 8'h15
`define RFC_IDX_FORCE1 8'h18
`define RFC_IDX_FORCE2 8'h19
`define RFC_IDX_FORCE3 8'h1a
`define RFC_IDX_IDLE_BASE 8'h20
`define RFC_IDX_IDLE_LAST 8'h3f
`define RFC_IDX_MW1 8'h3c
`define RFC_IDX_MW2 8'h3d
`define RFC_IDX_MW3 8'h3e
`define RFC_IDX_SIG_BASE 8'h40
`define RFC_IDX_SIG_LAST 8'h4f
`define RFC_IDX_IRQ_STAT 8'h70
`define RFC_IDX_IRQ_MASK 8'h71
`define RFC_IDX_STATE 8'h72
`define RFC_IDX_CODE 8'h73
// reset value of every writable register
`define RFC_RST_VAL 8'h00
// field positions
`define RFC_BIT_FORCE_EN 4
`define RFC_BIT_D4RA 0
`define RFC_BIT_BOC_RST 7
`define RFC_BOC_CLR_LSB 4
`define RFC_BOC_VAL_LSB 1
`define RFC_SA_MASK_BITS 5'h1f
`define RFC_BOC_CTRL_RW 8'h36
// interrupt status bits
`define RFC_IRQ_SA 0
`define RFC_IRQ_RA 1
`define RFC_IRQ_VALID 2
`define RFC_IRQ_CLEAR 3
// remote alarm detection details
`define RFC_RA_FRAME 4'hc
`define RFC_RA_BIT 6
`define RFC_T1_CHANS 5'h18
// bit oriented code reset timing and pattern length
`define RFC_CLK_NS 20
`define RFC_BOC_RST_MAX_NS 250000
`define RFC_BOC_RST_NS 2000
`define RFC_BOC_RST_CYC (`RFC_BOC_RST_NS / `RFC_CLK_NS)
`define RFC_PAT_BITS 7'h10
// digital milliwatt byte sequence
`define RFC_MW0 8'h1e
`define RFC_MW1 8'h0b
`define RFC_MW2 8'h0b
`define RFC_MW3 8'h1e
`define RFC_MW4 8'h9e
`define RFC_MW5 8'h8b
`define RFC_MW6 8'h8b
`define RFC_MW7 8'h9e
`endif

// ===== core/rfc_top.v
// How it works
// R1 - d4 remote alarm: bit2 zeros or frame12 S-bit
// R2 - masked Sa4..Sa8 changes set latched flag
// R3 - code reset bit self-clears well under 250us
// R4 - filter settings applied only after code reset
// R5 - clear filter 16/32/48/64 bits ends code
// R6 - valid filter none/3/5/7 identical patterns
// R7 - no validating while clearing, one state at once
// R8 - one idle code register per channel
// R9 - idle codes 1-24 t1 only, 25-32 e1
// R10 - forced ones on data, signaling out untouched
// R11 - forcing only while control bit 4 set
// R12 - milliwatt code replaces enabled t1 channels
// R13 - sixteen read-only signaling registers, nibble pairs
// R14 - signaling registers frozen during loss of sync
// R15 - d4 copies A,B into C,D
// R16 - control bit 4 clear means no forcing
// R17 - registers read back, reserved bits zero
`timescale 1ns/1ps
`include "rfc_regs.vh"
module rfc_top #(
  parameter RST_CYC = `RFC_BOC_RST_CYC
) (
  input wire clock_i,
  input wire srst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg irq_o,
  input wire mode_e1_i,
  input wire d4_framing_i,
  input wire out_of_frame_i,
  input wire frame_end_i,
  input wire [3:0] frame_num_i,
  input wire sbit_valid_i,
  input wire sbit_i,
  input wire sa_valid_i,
  input wire [4:0] sa_bits_i,
  input wire boc_bit_valid_i,
  input wire boc_bit_i,
  input wire chan_strobe_i,
  input wire [4:0] chan_idx_i,
  input wire [7:0] chan_data_i,
  input wire sig_frame_i,
  input wire [3:0] chan_sig_i,
  input wire sig_update_i,
  output reg [7:0] rx_serial_data_out_o,
  output reg rx_serial_valid_o,
  output reg [3:0] rx_signaling_out_o,
  output reg [7:0] rx_idle_code_o,
  output reg remote_alarm_o,
  output reg code_valid_o,
  output reg [5:0] code_o,
  output reg code_cleared_flag_o
);
  localparam ST_IDLE = 1'b0; // hunting for a code
  localparam ST_VALID = 1'b1; // code declared, watching for loss
  localparam [15:0] RST_LOAD = RST_CYC - 1;

  // bus side
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o; // new access
  wire wr = req & wb_we_i & wb_sel_i[0]; // low lane write
  wire [7:0] idx = wb_adr_i[9:2]; // word index
  wire [7:0] wd = wb_dat_i[7:0];
  reg [7:0] rd_nxt; // read mux

  // control registers
  reg [7:0] sig_ctrl_r; // only force enable kept
  reg [7:0] mode14_r; // t1 alarm select or e1 sa masks
  reg [7:0] boc_ctrl_r; // filter fields as written
  reg [23:0] force_r; // force ones, bit0 = channel 1
  reg [23:0] mw_r; // milliwatt enable, bit0 = channel 1
  reg [7:0] idle_r [0:31]; // idle codes, index = channel-1
  reg [3:0] sig_r [0:31]; // received signaling nibbles
  reg [3:0] stat_r; // sticky events
  reg [3:0] mask_r; // event mask
  reg [3:0] ev; // events seen this cycle

  // code receiver state
  reg boc_rst_r; // reset in progress
  reg [15:0] rst_cnt_r;
  reg [1:0] act_val_r; // applied validation setting
  reg [1:0] act_clr_r; // applied clear setting
  reg boc_state_r;
  reg [15:0] sh_r; // received message bits
  reg [5:0] cand_r; // candidate code
  reg [2:0] cnt_r; // identical patterns seen
  reg [6:0] gap_r; // bits since last matching pattern

  // remote alarm and sa state
  reg az_r; // bit2 zero in every channel so far
  reg [4:0] sa_prev_r;
  reg sa_seen_r;
  reg [2:0] mw_ph_r; // milliwatt sequence phase

  integer i;

  // idle and milliwatt share words 3c..3e: t1 gives milliwatt
  wire mw_hit = ~mode_e1_i & (idx >= `RFC_IDX_MW1) & (idx <= `RFC_IDX_MW3);
  wire idle_hit = (idx >= `RFC_IDX_IDLE_BASE) & (idx <= `RFC_IDX_IDLE_LAST) & ~mw_hit;
  wire sig_hit = (idx >= `RFC_IDX_SIG_BASE) & (idx <= `RFC_IDX_SIG_LAST);
  wire [4:0] idle_sel = idx[4:0]; // 20h..3fh map to 0..31
  wire [3:0] sig_sel = idx[3:0];
  wire [4:0] sig_a = {1'b0, sig_sel} - 5'h01; // e1 upper nibble channel
  wire [4:0] sig_b = {1'b0, sig_sel} + 5'he; // e1 lower nibble
  wire [4:0] sig_t = {1'b0, sig_sel} + 5'hc; // t1 lower nibble

  // message bits after the current one shifts in
  wire [15:0] sh_nxt = {sh_r[14:0], boc_bit_i};
  wire pat = (sh_nxt[15:8] == 8'hff) & ~sh_nxt[7] & ~sh_nxt[0];
  wire [5:0] pcode = sh_nxt[6:1];
  // R6 validation count decode
  wire [2:0] need = (act_val_r == 2'b00) ? 3'h1 : {act_val_r, 1'b1};
  // R5 clear count decode, multiples of 16 bits
  wire [6:0] clr_bits = {act_clr_r + 2'b01, 4'h0} | {act_clr_r == 2'b11, 6'h0};

  // register read mux
  always @* begin
    rd_nxt = 8'h00;
    // R17 read back, reserved zero
    if (idx == `RFC_IDX_SIG_CTRL)
      rd_nxt = sig_ctrl_r;
    else if (idx == `RFC_IDX_MODE14)
      rd_nxt = mode14_r;
    else if (idx == `RFC_IDX_BOC_CTRL)
      rd_nxt = {boc_rst_r, boc_ctrl_r[6:0]};
    else if (idx == `RFC_IDX_FORCE1)
      rd_nxt = force_r[7:0];
    else if (idx == `RFC_IDX_FORCE2)
      rd_nxt = force_r[15:8];
    else if (idx == `RFC_IDX_FORCE3)
      rd_nxt = force_r[23:16];
    else if (mw_hit) begin
      case (idx[1:0])
        2'b00: rd_nxt = mw_r[7:0];
        2'b01: rd_nxt = mw_r[15:8];
        default: rd_nxt = mw_r[23:16];
      endcase
    end else if (idle_hit)
      rd_nxt = idle_r[idle_sel];
    else if (sig_hit) begin
      // R13 t1: channel n high nibble, n+12 low nibble; e1: channel n high, n+15 low
      if (!mode_e1_i)
        rd_nxt = (sig_sel < 4'hc) ? {sig_r[{1'b0, sig_sel}], sig_r[sig_t]} : 8'h00;
      else if (sig_sel == 4'h0)
        rd_nxt = {4'h0, sig_r[31]};
      else
        rd_nxt = {sig_r[sig_a], sig_r[sig_b]};
    end else if (idx == `RFC_IDX_IRQ_STAT)
      rd_nxt = {4'h0, stat_r};
    else if (idx == `RFC_IDX_IRQ_MASK)
      rd_nxt = {4'h0, mask_r};
    else if (idx == `RFC_IDX_STATE)
      rd_nxt = {boc_rst_r, boc_state_r, remote_alarm_o, 5'h00};
    else if (idx == `RFC_IDX_CODE)
      rd_nxt = {2'b00, code_o};
  end

  // wishbone answer: ack one cycle after the request
  always @(posedge clock_i) begin
    if (srst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (req)
        wb_dat_o <= {24'h000000, rd_nxt};
    end
  end

  // writable registers
  always @(posedge clock_i) begin
    if (srst_i) begin
      sig_ctrl_r <= `RFC_RST_VAL;
      mode14_r <= `RFC_RST_VAL;
      boc_ctrl_r <= `RFC_RST_VAL;
      force_r <= {3{`RFC_RST_VAL}};
      mw_r <= {3{`RFC_RST_VAL}};
      mask_r <= 4'h0;
      for (i = 0; i < 32; i = i + 1)
        idle_r[i] <= `RFC_RST_VAL;
    end else if (wr) begin
      // only the force enable bit is held here
      if (idx == `RFC_IDX_SIG_CTRL)
        sig_ctrl_r <= wd & (8'h01 << `RFC_BIT_FORCE_EN);
      if (idx == `RFC_IDX_MODE14)
        mode14_r <= wd & {3'b000, `RFC_SA_MASK_BITS};
      // R4 stored only, applied at reset end
      if (idx == `RFC_IDX_BOC_CTRL)
        boc_ctrl_r <= wd & `RFC_BOC_CTRL_RW;
      if (idx == `RFC_IDX_FORCE1)
        force_r[7:0] <= wd;
      if (idx == `RFC_IDX_FORCE2)
        force_r[15:8] <= wd;
      if (idx == `RFC_IDX_FORCE3)
        force_r[23:16] <= wd;
      if (mw_hit) begin
        case (idx[1:0])
          2'b00: mw_r[7:0] <= wd;
          2'b01: mw_r[15:8] <= wd;
          default: mw_r[23:16] <= wd;
        endcase
      end
      // R8 idle code per channel
      if (idle_hit)
        idle_r[idle_sel] <= wd;
      if (idx == `RFC_IDX_IRQ_MASK)
        mask_r <= wd[3:0];
    end
  end

  // sticky status: set wins over write-one-to-clear
  always @(posedge clock_i) begin
    if (srst_i) begin
      stat_r <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      if (wr && idx == `RFC_IDX_IRQ_STAT)
        stat_r <= (stat_r & ~wd[3:0]) | ev;
      else
        stat_r <= stat_r | ev;
      irq_o <= |(stat_r & mask_r);
    end
  end

  // code receiver reset sequencing
  always @(posedge clock_i) begin
    if (srst_i) begin
      boc_rst_r <= 1'b0;
      rst_cnt_r <= 16'h0000;
      act_val_r <= 2'b00;
      act_clr_r <= 2'b00;
    end else if (wr && idx == `RFC_IDX_BOC_CTRL && wd[`RFC_BIT_BOC_RST]) begin
      // R3 host starts the reset, a rewrite restarts it
      boc_rst_r <= 1'b1;
      rst_cnt_r <= RST_LOAD;
    end else if (boc_rst_r) begin
      if (rst_cnt_r == 16'h0000) begin
        // R3 self-clear when done
        boc_rst_r <= 1'b0;
        // R4 new filters take effect now
        act_val_r <= boc_ctrl_r[`RFC_BOC_VAL_LSB +: 2];
        act_clr_r <= boc_ctrl_r[`RFC_BOC_CLR_LSB +: 2];
      end else
        rst_cnt_r <= rst_cnt_r - 16'h0001;
    end
  end

  // code receiver: validate, then watch for loss
  always @(posedge clock_i) begin
    if (srst_i || boc_rst_r) begin
      boc_state_r <= ST_IDLE;
      sh_r <= 16'h0000;
      cand_r <= 6'h00;
      cnt_r <= 3'h0;
      gap_r <= 7'h00;
      code_valid_o <= 1'b0;
      code_o <= 6'h00;
      code_cleared_flag_o <= 1'b0;
    end else begin
      code_cleared_flag_o <= 1'b0;
      if (boc_bit_valid_i) begin
        sh_r <= sh_nxt;
        // R7 one phase at a time
        case (boc_state_r)
          ST_IDLE: begin
            if (pat) begin
              gap_r <= 7'h00;
              // R6 count identical back-to-back patterns
              if (cnt_r != 3'h0 && cand_r == pcode && gap_r == `RFC_PAT_BITS - 7'h1) begin
                cnt_r <= cnt_r + 3'h1;
                if (cnt_r + 3'h1 >= need) begin
                  boc_state_r <= ST_VALID;
                  code_valid_o <= 1'b1;
                  code_o <= pcode;
                  cnt_r <= 3'h0;
                end
              end else begin
                cnt_r <= 3'h1;
                cand_r <= pcode;
                if (need == 3'h1) begin
                  boc_state_r <= ST_VALID;
                  code_valid_o <= 1'b1;
                  code_o <= pcode;
                  cnt_r <= 3'h0;
                end
              end
            end else begin
              if (gap_r != 7'h7f)
                gap_r <= gap_r + 7'h1;
              if (gap_r >= `RFC_PAT_BITS - 7'h1)
                cnt_r <= 3'h0;
            end
          end
          ST_VALID: begin
            // R5 consecutive bits without the code end it
            if (pat && pcode == code_o)
              gap_r <= 7'h00;
            else if (gap_r + 7'h1 >= clr_bits) begin
              boc_state_r <= ST_IDLE;
              code_valid_o <= 1'b0;
              code_cleared_flag_o <= 1'b1;
              gap_r <= 7'h00;
            end else
              gap_r <= gap_r + 7'h1;
          end
          default: boc_state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // event collection for the status register
  always @* begin
    ev = 4'h0;
    ev[`RFC_IRQ_VALID] = ~boc_rst_r & boc_bit_valid_i & ~boc_state_r & pat &
                         (need == 3'h1 | (cnt_r != 3'h0 & cand_r == pcode &
                         gap_r == `RFC_PAT_BITS - 7'h1 & cnt_r + 3'h1 >= need));
    ev[`RFC_IRQ_CLEAR] = ~boc_rst_r & boc_bit_valid_i & boc_state_r &
                         ~(pat & pcode == code_o) & (gap_r + 7'h1 >= clr_bits);
    // R2 masked sa change sets latched flag
    ev[`RFC_IRQ_SA] = mode_e1_i & sa_valid_i & sa_seen_r &
                      (|((sa_bits_i ^ sa_prev_r) & mode14_r[4:0]));
    ev[`RFC_IRQ_RA] = 1'b0;
    if (!mode_e1_i && d4_framing_i) begin
      if (mode14_r[`RFC_BIT_D4RA])
        ev[`RFC_IRQ_RA] = ~remote_alarm_o & sbit_valid_i &
                          (frame_num_i == `RFC_RA_FRAME) & sbit_i;
      else
        ev[`RFC_IRQ_RA] = ~remote_alarm_o & frame_end_i & az_r;
    end
  end

  // remote alarm detection and sa bit history
  always @(posedge clock_i) begin
    if (srst_i) begin
      remote_alarm_o <= 1'b0;
      az_r <= 1'b1;
      sa_prev_r <= 5'h00;
      sa_seen_r <= 1'b0;
    end else begin
      if (sa_valid_i) begin
        sa_prev_r <= sa_bits_i;
        sa_seen_r <= 1'b1;
      end
      if (mode_e1_i || !d4_framing_i) begin
        remote_alarm_o <= 1'b0;
        az_r <= 1'b1;
      end else if (mode14_r[`RFC_BIT_D4RA]) begin
        // R1 j1 style: S-bit of frame 12
        if (sbit_valid_i && frame_num_i == `RFC_RA_FRAME)
          remote_alarm_o <= sbit_i;
      end else begin
        // R1 bit 2 zero in all channels of a frame
        if (frame_end_i) begin
          remote_alarm_o <= az_r;
          az_r <= 1'b1;
        end else if (chan_strobe_i && chan_idx_i < `RFC_T1_CHANS &&
                     chan_data_i[`RFC_RA_BIT])
          az_r <= 1'b0;
      end
    end
  end

  // signaling registers, frozen out of frame
  always @(posedge clock_i) begin
    if (srst_i) begin
      for (i = 0; i < 32; i = i + 1)
        sig_r[i] <= 4'h0;
    end else if (sig_update_i && !out_of_frame_i) begin
      // R14 update only while in sync
      if (!mode_e1_i && d4_framing_i)
        // R15 repeat A,B into C,D
        sig_r[chan_idx_i] <= {chan_sig_i[3:2], chan_sig_i[3:2]};
      else
        sig_r[chan_idx_i] <= chan_sig_i;
    end
  end

  // milliwatt byte for the current phase
  function [7:0] mw_byte;
    input [2:0] ph;
    begin
      case (ph)
        3'h0: mw_byte = `RFC_MW0;
        3'h1: mw_byte = `RFC_MW1;
        3'h2: mw_byte = `RFC_MW2;
        3'h3: mw_byte = `RFC_MW3;
        3'h4: mw_byte = `RFC_MW4;
        3'h5: mw_byte = `RFC_MW5;
        3'h6: mw_byte = `RFC_MW6;
        default: mw_byte = `RFC_MW7;
      endcase
    end
  endfunction

  wire t1_ch = ~mode_e1_i & (chan_idx_i < `RFC_T1_CHANS);
  wire [4:0] ch24 = t1_ch ? chan_idx_i : 5'h00;

  // receive data path substitution
  always @(posedge clock_i) begin
    if (srst_i) begin
      rx_serial_data_out_o <= 8'h00;
      rx_serial_valid_o <= 1'b0;
      rx_signaling_out_o <= 4'h0;
      rx_idle_code_o <= 8'h00;
      mw_ph_r <= 3'h0;
    end else begin
      rx_serial_valid_o <= chan_strobe_i;
      if (frame_end_i)
        mw_ph_r <= mw_ph_r + 3'h1;
      if (chan_strobe_i) begin
        // R10 signaling output always reports what arrived
        rx_signaling_out_o <= chan_sig_i;
        // R12 milliwatt replaces the whole byte
        if (t1_ch && mw_r[ch24])
          rx_serial_data_out_o <= mw_byte(mw_ph_r);
        // R11 R16 forcing gated by control bit 4
        else if (t1_ch && sig_ctrl_r[`RFC_BIT_FORCE_EN] && force_r[ch24] && sig_frame_i)
          rx_serial_data_out_o <= chan_data_i | 8'h01;
        else
          rx_serial_data_out_o <= chan_data_i;
        // R9 idle codes 1-24 t1, 25-32 e1
        if (t1_ch || (mode_e1_i && chan_idx_i >= `RFC_T1_CHANS))
          rx_idle_code_o <= idle_r[chan_idx_i];
        else
          rx_idle_code_o <= 8'h00;
      end
    end
  end
endmodule

// ===== testbench/rfc_props.sv
`timescale 1ns/1ps
// port-level timing checks for the receive framer control block
module rfc_props (
  input wire clock_i,
  input wire srst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire mode_e1_i,
  input wire frame_end_i,
  input wire sbit_valid_i,
  input wire boc_bit_valid_i,
  input wire chan_strobe_i,
  input wire [4:0] chan_idx_i,
  input wire [7:0] chan_data_i,
  input wire [3:0] chan_sig_i,
  input wire rx_serial_valid_o,
  input wire [7:0] rx_serial_data_out_o,
  input wire [3:0] rx_signaling_out_o,
  input wire [7:0] rx_idle_code_o,
  input wire remote_alarm_o,
  input wire code_valid_o,
  input wire code_cleared_flag_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // a taken request is answered on the very next edge
  ack_follow_a: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack missing");
  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  // signaling pin reports what arrived, whatever forcing does to data
  sig_pass_a: assert property (
    chan_strobe_i |=> rx_serial_valid_o && rx_signaling_out_o == $past(chan_sig_i))
    else $error("signaling out altered");
  e1_clean_a: assert property (
    chan_strobe_i && mode_e1_i |=> rx_serial_data_out_o == $past(chan_data_i))
    else $error("e1 data altered");
  idle_mode_a: assert property (
    chan_strobe_i && (mode_e1_i ? chan_idx_i < 5'h18 : chan_idx_i > 5'h17)
    |=> rx_idle_code_o == 8'h00) else $error("idle code outside its mode");
  alarm_cause_a: assert property (
    $rose(remote_alarm_o) |-> $past(frame_end_i || sbit_valid_i)
    || $past(frame_end_i || sbit_valid_i, 2)) else $error("alarm rose without event");
  valid_cause_a: assert property (
    $rose(code_valid_o) |-> $past(boc_bit_valid_i) || $past(boc_bit_valid_i, 2))
    else $error("code valid without bit");
  clear_pulse_a: assert property (
    code_cleared_flag_o |-> !code_valid_o ##1 !code_cleared_flag_o)
    else $error("cleared flag wrong");
endmodule

// ===== testbench/rfc_top_tb.sv
`timescale 1ns/1ps
`include "rfc_regs.vh"
module rfc_top_tb;
  reg clock_i = 1'b0;
  reg srst_i = 1'b1;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [11:0] wb_adr_i = 12'h000;
  reg [3:0] wb_sel_i = 4'h1;
  reg [31:0] wb_dat_i = 32'h0;
  reg mode_e1_i = 1'b0;
  reg d4_framing_i = 1'b0;
  reg out_of_frame_i = 1'b0;
  reg frame_end_i = 1'b0;
  reg [3:0] frame_num_i = 4'h0;
  reg sbit_valid_i = 1'b0;
  reg sbit_i = 1'b0;
  reg sa_valid_i = 1'b0;
  reg [4:0] sa_bits_i = 5'h00;
  reg boc_bit_valid_i = 1'b0;
  reg boc_bit_i = 1'b0;
  reg chan_strobe_i = 1'b0;
  reg [4:0] chan_idx_i = 5'h00;
  reg [7:0] chan_data_i = 8'h00;
  reg sig_frame_i = 1'b0;
  reg [3:0] chan_sig_i = 4'h0;
  reg sig_update_i = 1'b0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire irq_o;
  wire [7:0] rx_serial_data_out_o;
  wire rx_serial_valid_o;
  wire [3:0] rx_signaling_out_o;
  wire [7:0] rx_idle_code_o;
  wire remote_alarm_o;
  wire code_valid_o;
  wire [5:0] code_o;
  wire code_cleared_flag_o;
  integer error_cnt = 0;
  integer checked = 0;
  integer i;
  integer n;
  reg [7:0] rd;
  // register table rows: index, written value, value read back
  reg [7:0] row_idx [12] = '{8'h13, 8'h14, 8'h15, 8'h18, 8'h19, 8'h1a,
                             8'h20, 8'h37, 8'h3f, 8'h3c, 8'h40, 8'h7f};
  reg [7:0] row_wr [12] = '{8'hff, 8'hff, 8'h36, 8'ha5, 8'h3c, 8'hc3,
                            8'h11, 8'h24, 8'h7e, 8'h01, 8'hff, 8'hff};
  reg [7:0] row_rd [12] = '{8'h10, 8'h1f, 8'h36, 8'ha5, 8'h3c, 8'hc3,
                            8'h11, 8'h24, 8'h7e, 8'h01, 8'h00, 8'h00};
  // short reset count keeps the code receiver reset quick
  rfc_top #(.RST_CYC(8)) i_rfc_top (.*);
  initial begin
    forever #10 clock_i = ~clock_i;
  end
  task end_of_test;
    begin
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input string name, input [7:0] exp, input [7:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task tick(input integer k);
    repeat (k) @(posedge clock_i);
  endtask
  // one classic bus cycle, held until ack is sampled
  task wb(input w, input [7:0] idx, input [7:0] wd, output [7:0] rdv);
    integer k;
    begin
      k = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= {2'b00, idx, 2'b00};
      wb_dat_i <= {24'h0, wd};
      @(posedge clock_i);
      while (wb_ack_o !== 1'b1 && k < 20) begin
        @(posedge clock_i);
        k = k + 1;
      end
      if (k == 20) begin
        error_cnt = error_cnt + 1;
        end_of_test;
      end
      rdv = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clock_i);
    end
  endtask
  task wr(input [7:0] idx, input [7:0] v);
    wb(1'b1, idx, v, rd);
  endtask
  task rc(input [7:0] idx, input [7:0] exp);
    begin
      wb(1'b0, idx, 8'h00, rd);
      chk($sformatf("reg %h", idx), exp, rd);
      chk("read upper", 8'h00, {7'h0, |wb_dat_o[31:8]});
    end
  endtask
  // one channel slot, outputs checked the cycle after it
  task strb(input [4:0] ix, input [7:0] d, input [3:0] s, input sf, input up,
            input [7:0] ed, input [7:0] ei);
    begin
      chan_strobe_i <= 1'b1;
      chan_idx_i <= ix;
      chan_data_i <= d;
      chan_sig_i <= s;
      sig_frame_i <= sf;
      sig_update_i <= up;
      @(posedge clock_i);
      chan_strobe_i <= 1'b0;
      sig_update_i <= 1'b0;
      @(posedge clock_i);
      chk("serial valid", 8'h01, {7'h0, rx_serial_valid_o});
      chk("serial data", ed, rx_serial_data_out_o);
      chk("signaling out", {4'h0, s}, {4'h0, rx_signaling_out_o});
      chk("idle code", ei, rx_idle_code_o);
    end
  endtask
  task sb(input [3:0] f, input v);
    begin
      sbit_valid_i <= 1'b1;
      frame_num_i <= f;
      sbit_i <= v;
      @(posedge clock_i);
      sbit_valid_i <= 1'b0;
      tick(2);
    end
  endtask
  task sa(input [4:0] v);
    begin
      sa_valid_i <= 1'b1;
      sa_bits_i <= v;
      @(posedge clock_i);
      sa_valid_i <= 1'b0;
      tick(2);
    end
  endtask
  task fe;
    begin
      frame_end_i <= 1'b1;
      @(posedge clock_i);
      frame_end_i <= 1'b0;
      tick(2);
    end
  endtask
  // message bits, oldest first
  task bits(input [15:0] w, input integer k);
    integer j;
    begin
      for (j = 0; j < k; j = j + 1) begin
        boc_bit_valid_i <= 1'b1;
        boc_bit_i <= w[15-j];
        @(posedge clock_i);
      end
      boc_bit_valid_i <= 1'b0;
      tick(3);
    end
  endtask
  initial begin
    tick(20000);
    error_cnt = error_cnt + 1;
    end_of_test;
  end
  initial begin
    tick(8);
    srst_i <= 1'b0;
    @(posedge clock_i);
    chk("irq after reset", 8'h00, {7'h0, irq_o});
    for (i = 0; i < 12; i = i + 1) begin
      rc(row_idx[i], 8'h00);
      wr(row_idx[i], row_wr[i]);
      rc(row_idx[i], row_rd[i]);
    end
    // datapath: milliwatt, forcing, T1 and E1 idle codes
    strb(5'h00, 8'h40, 4'h5, 1'b1, 1'b0, `RFC_MW0, 8'h11);
    strb(5'h02, 8'h40, 4'h5, 1'b1, 1'b0, 8'h41, 8'h00);
    strb(5'h02, 8'h40, 4'h5, 1'b0, 1'b0, 8'h40, 8'h00);
    strb(5'h01, 8'h40, 4'h5, 1'b1, 1'b0, 8'h40, 8'h00);
    strb(5'h17, 8'h40, 4'h5, 1'b1, 1'b0, 8'h41, 8'h24);
    strb(5'h1f, 8'h40, 4'h5, 1'b1, 1'b0, 8'h40, 8'h00);
    wr(8'h13, 8'h00);
    strb(5'h02, 8'h40, 4'h5, 1'b1, 1'b0, 8'h40, 8'h00);
    mode_e1_i <= 1'b1;
    strb(5'h1f, 8'h40, 4'h5, 1'b1, 1'b0, 8'h40, 8'h7e);
    mode_e1_i <= 1'b0;
    // signaling registers: nibble pairs, D4 copy, frozen out of frame
    strb(5'h01, 8'h40, 4'ha, 1'b0, 1'b1, 8'h40, 8'h00);
    strb(5'h0d, 8'h40, 4'h6, 1'b0, 1'b1, 8'h40, 8'h00);
    d4_framing_i <= 1'b1;
    strb(5'h02, 8'h40, 4'h8, 1'b0, 1'b1, 8'h40, 8'h00);
    strb(5'h0e, 8'h40, 4'h7, 1'b0, 1'b1, 8'h40, 8'h00);
    out_of_frame_i <= 1'b1;
    strb(5'h01, 8'h40, 4'h0, 1'b0, 1'b1, 8'h40, 8'h00);
    out_of_frame_i <= 1'b0;
    rc(8'h41, 8'ha6);
    rc(8'h42, 8'ha5);
    // remote alarm by frame 12 S-bit, with interrupt
    wr(8'h71, 8'h02);
    sb(4'hb, 1'b1);
    chk("alarm", 8'h00, {7'h0, remote_alarm_o});
    sb(4'hc, 1'b1);
    chk("alarm", 8'h01, {7'h0, remote_alarm_o});
    chk("irq", 8'h01, {7'h0, irq_o});
    wr(8'h70, 8'h02);
    tick(1);
    chk("irq", 8'h00, {7'h0, irq_o});
    wr(8'h71, 8'h00);
    sb(4'hc, 1'b0);
    sb(4'hc, 1'b1);
    chk("irq", 8'h00, {7'h0, irq_o});
    rc(8'h70, 8'h02);
    wr(8'h70, 8'h02);
    // remote alarm by bit 2 zeros
    wr(8'h14, 8'h00);
    strb(5'h04, 8'h40, 4'h0, 1'b0, 1'b0, 8'h40, 8'h00);
    fe;
    chk("alarm", 8'h00, {7'h0, remote_alarm_o});
    fe;
    chk("alarm", 8'h01, {7'h0, remote_alarm_o});
    rc(8'h70, 8'h02);
    wr(8'h70, 8'h02);
    // Sa change interrupt, per-bit mask
    mode_e1_i <= 1'b1;
    d4_framing_i <= 1'b0;
    wr(8'h14, 8'h01);
    wr(8'h71, 8'h01);
    sa(5'h00);
    sa(5'h10);
    rc(8'h70, 8'h00);
    sa(5'h11);
    rc(8'h70, 8'h01);
    chk("irq", 8'h01, {7'h0, irq_o});
    wr(8'h70, 8'h01);
    rc(8'h70, 8'h00);
    // code receiver: old filters until reset, then 3 patterns, 16 bit clear
    mode_e1_i <= 1'b0;
    bits({8'hff, 1'b0, 6'h15, 1'b0}, 16);
    chk("code valid", 8'h01, {7'h0, code_valid_o});
    chk("code", 8'h15, {2'b00, code_o});
    wr(8'h15, 8'h82);
    rc(8'h15, 8'h82);
    chk("code valid", 8'h00, {7'h0, code_valid_o});
    n = 0;
    rd = 8'h80;
    while (rd[7] && n < 30) begin
      wb(1'b0, 8'h15, 8'h00, rd);
      n = n + 1;
    end
    chk("reset done", 8'h02, rd);
    bits({8'hff, 1'b0, 6'h2a, 1'b0}, 16);
    bits({8'hff, 1'b0, 6'h2a, 1'b0}, 16);
    chk("code valid", 8'h00, {7'h0, code_valid_o});
    bits({8'hff, 1'b0, 6'h2a, 1'b0}, 16);
    chk("code valid", 8'h01, {7'h0, code_valid_o});
    chk("code", 8'h2a, {2'b00, code_o});
    // a different code while valid only counts towards clearing
    bits({8'hff, 1'b0, 6'h15, 1'b0}, 15);
    chk("code valid", 8'h01, {7'h0, code_valid_o});
    boc_bit_i <= 1'b0;
    boc_bit_valid_i <= 1'b1;
    @(posedge clock_i);
    boc_bit_valid_i <= 1'b0;
    @(negedge clock_i);
    chk("cleared flag", 8'h01, {7'h0, code_cleared_flag_o});
    @(negedge clock_i);
    chk("cleared flag", 8'h00, {7'h0, code_cleared_flag_o});
    tick(1);
    chk("code valid", 8'h00, {7'h0, code_valid_o});
    chk("code", 8'h2a, {2'b00, code_o});
    rc(8'h70, 8'h0c);
    // mid-run reset clears registers and outputs
    srst_i <= 1'b1;
    tick(2);
    srst_i <= 1'b0;
    @(posedge clock_i);
    chk("data after reset", 8'h00, rx_serial_data_out_o);
    rc(8'h18, 8'h00);
    rc(8'h20, 8'h00);
    rc(8'h70, 8'h00);
    end_of_test;
  end
endmodule
bind rfc_top rfc_props i_rfc_props (.*);
